/* logic/loop_ctrl_defs.svh */
// Register offsets, field positions, reset values and size constants for the input loop control bank
`ifndef LOOP_CTRL_DEFS_SVH
`define LOOP_CTRL_DEFS_SVH

`define ADDR_W 12
`define OFF_REF_A_LOW 12'h010
`define OFF_REF_A_HIGH 12'h011
`define OFF_REF_B_LOW 12'h012
`define OFF_REF_B_HIGH 12'h013
`define OFF_TEST_REF 12'h014
`define OFF_LOOP_RSVD 12'h015
`define OFF_FB_LOW 12'h016
`define OFF_FB_HIGH 12'h017
`define OFF_PUMP_CUR 12'h018
`define OFF_PUMP_MODE 12'h019
`define OFF_MISC 12'h01C
`define OFF_READBACK 12'h004

`define RDIV_W 10
`define TDIV_W 6
`define HIGH_MASK 8'h03
`define TEST_MASK 8'h3F
`define MODE_MASK 8'h1F
`define MISC_MASK 8'h80
`define READBACK_MASK 8'h01
`define PUMP_TRI_BIT 7
`define BACKLASH_EN_BIT 4
`define BACKLASH_LSB 2
`define MISC_INDEP_BIT 7
`define BACKLASH_HIGH 2'h2

`define RST_BYTE 8'h00
`define RST_PUMP_MODE 8'h08

`endif

/* logic/loop_ctrl_pkg.sv */
// Types shared by the input loop control bank
package loop_ctrl_pkg;
	typedef enum logic [1:0] {
		BL_MIN,
		BL_LOW,
		BL_HIGH,
		BL_MAX
	} backlash_e;

	typedef enum logic [1:0] {
		PUMP_TRISTATE,
		PUMP_UP,
		PUMP_DOWN,
		PUMP_NORMAL
	} pump_mode_e;
endpackage : loop_ctrl_pkg

/* logic/modulus_counter.sv */
// Reloading modulus counter: one output pulse per modulus input ticks
`timescale 1ns/1ns
module modulus_counter #(
	parameter int W = 10
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Count input and modulus
	input wire logic tick,
	input wire logic [W-1:0] modulus,
	// Terminal count pulse
	output logic pulse
);
	logic [W-1:0] count_reg;
	logic [W-1:0] last;

	// Zero and one both mean divide by one
	assign last = (modulus == '0) ? '0 : modulus - W'(1); // RULE2

	// Count up, reload at terminal count
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			count_reg <= '0;
			pulse <= 1'b0;
		end else if (tick) begin
			if (count_reg >= last) begin // RULE14
				count_reg <= '0;
				pulse <= 1'b1;
			end else begin
				count_reg <= count_reg + W'(1);
				pulse <= 1'b0;
			end
		end else begin
			pulse <= 1'b0;
		end
	end

	// No pulse without a tick: every pulse comes the cycle after a tick
	property p_pulse_after_tick;
		@(posedge core_clk) disable iff (rst) pulse |-> $past(tick);
	endproperty
	a_pulse_after_tick: assert property (p_pulse_after_tick) else $error("pulse without tick"); // RULE14

	// Modulus one passes every tick through
	property p_div_one;
		@(posedge core_clk) disable iff (rst)
			(tick && modulus <= W'(1) && $stable(modulus)) |=> pulse;
	endproperty
	a_div_one: assert property (p_div_one) else $error("divide by one missed a pulse"); // RULE2
endmodule : modulus_counter

/* logic/input_loop_ctrl.sv */
// Input loop divider and charge pump control register bank
`timescale 1ns/1ns
`include "loop_ctrl_defs.svh"

// Overview of operation
// RULE1: First reference divide ratio is 10 bits, low byte 0x010, bits 1:0 at 0x011.
// RULE2: Reference dividers divide by 1 to 1023; zero and one divide by one.
// RULE3: Second reference ratio: low byte 0x012, top bits 1:0 at 0x013.
// RULE4: Second reference divides independently only when 0x01C bit 7 is one.
// RULE5: Test divider uses 0x014 bits 5:0, divides 1 to 63, zero means one.
// RULE6: Feedback divider ratio from 0x016 and 0x017 bits 1:0, range 1 to 1023.
// RULE7: Bit 7 of 0x018 forces the charge pump output to high impedance.
// RULE8: Bits 6:0 of 0x018 set pump current linearly, half microamp per step.
// RULE9: With 0x019 bit 4 clear the backlash width is forced to high.
// RULE10: Backlash field 3:2 of 0x019: min, low, high, max; resets to high.
// RULE11: Pump mode field 1:0 of 0x019: tristate, up, down, normal; resets tristate.
// RULE12: Writes go to a shadow copy, applied only on the update command.
// RULE13: Reserved bits read zero and writes to them change nothing.
// RULE14: Counters reload at terminal count, one pulse per modulus ticks.
module input_loop_ctrl #(
	parameter int RDIV_W = `RDIV_W,
	parameter int TDIV_W = `TDIV_W
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Serial port register access
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [`ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic io_update,
	// Divider count inputs, same clock domain
	input wire logic first_reference_input_tick,
	input wire logic second_reference_input_tick,
	input wire logic test_ref_tick,
	input wire logic feedback_tick,
	// Divider outputs
	output logic first_ref_pulse,
	output logic second_ref_pulse,
	output logic test_ref_pulse,
	output logic feedback_pulse,
	// Charge pump controls
	output logic pump_hiz,
	output logic [6:0] pump_current,
	output loop_ctrl_pkg::pump_mode_e pump_mode,
	output loop_ctrl_pkg::backlash_e backlash_width
);
	// Register shadow and active copies indexed 0x010..0x01C low nibble + misc
	localparam int NREG = 13;
	logic [7:0] shadow_reg [NREG];
	logic [7:0] active_reg [NREG];
	logic readback_sel_reg;
	logic [RDIV_W-1:0] ref_a_mod;
	logic [RDIV_W-1:0] ref_b_mod;
	logic [RDIV_W-1:0] fb_mod;
	logic [TDIV_W-1:0] test_mod;
	logic [7:0] pump_cur_byte;
	logic [7:0] mode_byte;
	logic [3:0] idx;
	logic hit;

	// Writable mask per slot; reserved bits stay zero
	function automatic logic [7:0] slot_mask(input logic [3:0] i);
		case (i)
			4'h0, 4'h2, 4'h6, 4'h8: slot_mask = 8'hFF;
			4'h1, 4'h3, 4'h7: slot_mask = `HIGH_MASK; // RULE13
			4'h4: slot_mask = `TEST_MASK; // RULE5
			4'h9: slot_mask = `MODE_MASK; // RULE13
			4'hC: slot_mask = `MISC_MASK; // RULE4
			default: slot_mask = 8'h00; // RULE13
		endcase
	endfunction : slot_mask

	// Reset value per slot
	function automatic logic [7:0] slot_reset(input logic [3:0] i);
		if (i == 4'h9) begin
			slot_reset = `RST_PUMP_MODE; // RULE10
		end else begin
			slot_reset = `RST_BYTE; // RULE11
		end
	endfunction : slot_reset

	// Address decode into the 0x010..0x01C window
	assign hit = (reg_addr >= `OFF_REF_A_LOW) && (reg_addr <= `OFF_MISC);
	assign idx = reg_addr[3:0];

	// Shadow and active copies, one slot each
	genvar g;
	generate
		for (g = 0; g < NREG; g++) begin : g_slot
			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					shadow_reg[g] <= slot_reset(4'(g));
				end else if (reg_wr && hit && idx == 4'(g)) begin
					shadow_reg[g] <= reg_wdata & slot_mask(4'(g)); // RULE13
				end
			end

			// Active copy moves only on the update command
			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					active_reg[g] <= slot_reset(4'(g));
				end else if (io_update) begin
					active_reg[g] <= shadow_reg[g]; // RULE12
				end
			end

			// A write lands masked; reserved bits are dropped on the way in
			property p_slot_write;
				@(posedge core_clk) disable iff (rst)
					(reg_wr && hit && idx == 4'(g)) |=>
						(shadow_reg[g] == ($past(reg_wdata) & slot_mask(4'(g))));
			endproperty
			a_slot_write: assert property (p_slot_write) else $error("slot write lost"); // RULE12

			// Writes elsewhere, unmapped places too, leave the slot alone
			property p_slot_keep;
				@(posedge core_clk) disable iff (rst)
					!(reg_wr && hit && idx == 4'(g)) |=> $stable(shadow_reg[g]);
			endproperty
			a_slot_keep: assert property (p_slot_keep) else $error("slot moved unwritten"); // RULE13

			// Every slot is copied by one update, so paired bytes move together
			property p_slot_apply;
				@(posedge core_clk) disable iff (rst)
					io_update |=> (active_reg[g] == $past(shadow_reg[g]));
			endproperty
			a_slot_apply: assert property (p_slot_apply) else $error("update missed a slot"); // RULE12

			property p_slot_hold;
				@(posedge core_clk) disable iff (rst)
					!io_update |=> $stable(active_reg[g]);
			endproperty
			a_slot_hold: assert property (p_slot_hold) else $error("slot applied early"); // RULE12
		end
	endgenerate

	// Readback source select
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			readback_sel_reg <= 1'b0;
		end else if (reg_wr && reg_addr == `OFF_READBACK) begin
			readback_sel_reg <= reg_wdata[0];
		end
	end

	// Select is not buffered: it acts on the very next read
	property p_rb_sel;
		@(posedge core_clk) disable iff (rst)
			(reg_wr && reg_addr == `OFF_READBACK) |=> (readback_sel_reg == $past(reg_wdata[0]));
	endproperty
	a_rb_sel: assert property (p_rb_sel) else $error("readback select write lost"); // RULE12

	property p_rb_keep;
		@(posedge core_clk) disable iff (rst)
			!(reg_wr && reg_addr == `OFF_READBACK) |=> $stable(readback_sel_reg);
	endproperty
	a_rb_keep: assert property (p_rb_keep) else $error("readback select moved"); // RULE12

	// Registered read data; 0 shows active, 1 shows shadow
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			if (reg_addr == `OFF_READBACK) begin
				reg_rdata <= {7'h00, readback_sel_reg};
			end else if (hit) begin
				reg_rdata <= readback_sel_reg ? shadow_reg[idx] : active_reg[idx]; // RULE13
			end else begin
				reg_rdata <= 8'h00;
			end
		end
	end

	// Read data stands until the next read strobe, so a slow master can take it late
	property p_rdata_hold;
		@(posedge core_clk) disable iff (rst)
			!reg_rd |=> $stable(reg_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved unread"); // RULE12

	// Places outside the bank, except the readback select at 0x004, read as zero
	property p_rdata_unmapped;
		@(posedge core_clk) disable iff (rst)
			(reg_rd && !hit && reg_addr != `OFF_READBACK) |=> (reg_rdata == 8'h00);
	endproperty
	a_rdata_unmapped: assert property (p_rdata_unmapped) else $error("unmapped not zero"); // RULE13

	// Select clear shows what the loop logic is using now
	property p_rdata_active;
		@(posedge core_clk) disable iff (rst)
			(reg_rd && hit && !readback_sel_reg) |=> (reg_rdata == $past(active_reg[idx]));
	endproperty
	a_rdata_active: assert property (p_rdata_active) else $error("active readback wrong"); // RULE12

	property p_rdata_shadow;
		@(posedge core_clk) disable iff (rst)
			(reg_rd && hit && readback_sel_reg) |=> (reg_rdata == $past(shadow_reg[idx]));
	endproperty
	a_rdata_shadow: assert property (p_rdata_shadow) else $error("shadow readback wrong"); // RULE12

	// Reserved bits of a bank byte always read clear
	property p_rdata_rsvd;
		@(posedge core_clk) disable iff (rst)
			(reg_rd && hit) |=> ((reg_rdata & ~slot_mask($past(idx))) == 8'h00);
	endproperty
	a_rdata_rsvd: assert property (p_rdata_rsvd) else $error("reserved bit read back"); // RULE13

	// Divider moduli from active bytes
	assign ref_a_mod = {active_reg[1][1:0], active_reg[0]}; // RULE1
	assign ref_b_mod = {active_reg[3][1:0], active_reg[2]}; // RULE3
	assign test_mod = active_reg[4][TDIV_W-1:0]; // RULE5
	assign fb_mod = {active_reg[7][1:0], active_reg[6]}; // RULE6
	assign pump_cur_byte = active_reg[8];
	assign mode_byte = active_reg[9];

	// Both bytes of a ratio reach the counter on the same update, never half of it
	property p_ref_a_pair;
		@(posedge core_clk) disable iff (rst)
			io_update |=> (ref_a_mod == {$past(shadow_reg[1][1:0]), $past(shadow_reg[0])});
	endproperty
	a_ref_a_pair: assert property (p_ref_a_pair) else $error("first ratio not applied"); // RULE1

	property p_ref_b_pair;
		@(posedge core_clk) disable iff (rst)
			io_update |=> (ref_b_mod == {$past(shadow_reg[3][1:0]), $past(shadow_reg[2])});
	endproperty
	a_ref_b_pair: assert property (p_ref_b_pair) else $error("second ratio not applied"); // RULE3

	property p_fb_pair;
		@(posedge core_clk) disable iff (rst)
			io_update |=> (fb_mod == {$past(shadow_reg[7][1:0]), $past(shadow_reg[6])});
	endproperty
	a_fb_pair: assert property (p_fb_pair) else $error("feedback ratio not applied"); // RULE6

	property p_test_ratio;
		@(posedge core_clk) disable iff (rst)
			io_update |=> (test_mod == $past(shadow_reg[4][TDIV_W-1:0]));
	endproperty
	a_test_ratio: assert property (p_test_ratio) else $error("test ratio not applied"); // RULE5

	modulus_counter #(.W(RDIV_W)) u_ref_a (
		.core_clk(core_clk),
		.rst(rst),
		.tick(first_reference_input_tick),
		.modulus(ref_a_mod),
		.pulse(first_ref_pulse)
	);

	// Without independent mode the second path shares the first ratio
	modulus_counter #(.W(RDIV_W)) u_ref_b (
		.core_clk(core_clk),
		.rst(rst),
		.tick(second_reference_input_tick),
		.modulus(active_reg[12][`MISC_INDEP_BIT] ? ref_b_mod : ref_a_mod), // RULE4
		.pulse(second_ref_pulse)
	);

	modulus_counter #(.W(TDIV_W)) u_test (
		.core_clk(core_clk),
		.rst(rst),
		.tick(test_ref_tick),
		.modulus(test_mod),
		.pulse(test_ref_pulse)
	);

	modulus_counter #(.W(RDIV_W)) u_fb (
		.core_clk(core_clk),
		.rst(rst),
		.tick(feedback_tick),
		.modulus(fb_mod),
		.pulse(feedback_pulse)
	);

	// Pump controls registered from active values
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pump_hiz <= 1'b0;
			pump_current <= 7'h00;
			pump_mode <= loop_ctrl_pkg::PUMP_TRISTATE;
			backlash_width <= loop_ctrl_pkg::BL_HIGH;
		end else begin
			pump_hiz <= pump_cur_byte[`PUMP_TRI_BIT]; // RULE7
			pump_current <= pump_cur_byte[6:0]; // RULE8
			pump_mode <= loop_ctrl_pkg::pump_mode_e'(mode_byte[1:0]); // RULE11
			// Automatic mode pins the width at high regardless of the field
			if (mode_byte[`BACKLASH_EN_BIT]) begin
				backlash_width <= loop_ctrl_pkg::backlash_e'(mode_byte[3:2]); // RULE10
			end else begin
				backlash_width <= loop_ctrl_pkg::BL_HIGH; // RULE9
			end
		end
	end

	// Shadow write does not reach the pump until update
	property p_shadow_hold;
		@(posedge core_clk) disable iff (rst)
			(!io_update) |=> $stable(active_reg[8]);
	endproperty
	a_shadow_hold: assert property (p_shadow_hold) else $error("active changed without update"); // RULE12

	property p_update_copy;
		@(posedge core_clk) disable iff (rst)
			io_update |=> (active_reg[9] == $past(shadow_reg[9]));
	endproperty
	a_update_copy: assert property (p_update_copy) else $error("update did not copy shadow"); // RULE12

	property p_hiz;
		@(posedge core_clk) disable iff (rst)
			1'b1 |=> (pump_hiz == $past(active_reg[8][7]));
	endproperty
	a_hiz: assert property (p_hiz) else $error("tristate bit not applied"); // RULE7

	property p_current;
		@(posedge core_clk) disable iff (rst)
			1'b1 |=> (pump_current == $past(active_reg[8][6:0]));
	endproperty
	a_current: assert property (p_current) else $error("pump current mismatch"); // RULE8

	property p_backlash_auto;
		@(posedge core_clk) disable iff (rst)
			!active_reg[9][4] |=> (backlash_width == loop_ctrl_pkg::BL_HIGH);
	endproperty
	a_backlash_auto: assert property (p_backlash_auto) else $error("auto backlash not high"); // RULE9

	property p_backlash_field;
		@(posedge core_clk) disable iff (rst)
			active_reg[9][4] |=> (backlash_width == $past(active_reg[9][3:2]));
	endproperty
	a_backlash_field: assert property (p_backlash_field) else $error("backlash field ignored"); // RULE10

	property p_mode;
		@(posedge core_clk) disable iff (rst)
			1'b1 |=> (pump_mode == $past(active_reg[9][1:0]));
	endproperty
	a_mode: assert property (p_mode) else $error("pump mode mismatch"); // RULE11

	property p_rsvd_zero;
		@(posedge core_clk) disable iff (rst)
			(shadow_reg[9][7:5] == 3'h0) && (shadow_reg[5] == 8'h00) && (shadow_reg[4][7:6] == 2'h0);
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits stored"); // RULE13

	property p_ref_b_shared;
		@(posedge core_clk) disable iff (rst)
			!active_reg[12][7] |-> (u_ref_b.modulus == ref_a_mod);
	endproperty
	a_ref_b_shared: assert property (p_ref_b_shared) else $error("second ref not shared"); // RULE4

	c_update: cover property (@(posedge core_clk) disable iff (rst) io_update ##1 pump_hiz);
	c_fb_pulse: cover property (@(posedge core_clk) disable iff (rst) feedback_pulse);
	c_manual_bl: cover property (@(posedge core_clk) disable iff (rst)
		backlash_width == loop_ctrl_pkg::BL_MIN);
	c_indep: cover property (@(posedge core_clk) disable iff (rst) active_reg[12][7] && second_ref_pulse);
	c_rb_shadow: cover property (@(posedge core_clk) disable iff (rst) reg_rd && readback_sel_reg);
endmodule : input_loop_ctrl

/* test/input_loop_ctrl_tb.sv */
// Self-checking bench for the input loop control bank
`timescale 1ns/1ns
`include "loop_ctrl_defs.svh"
module input_loop_ctrl_tb;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [11:0] reg_addr = 12'h000;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic io_update = 1'b0;
	logic [3:0] tick = 4'h0;
	logic [3:0] pulse;
	logic pump_hiz;
	logic [6:0] pump_current;
	loop_ctrl_pkg::pump_mode_e pump_mode;
	loop_ctrl_pkg::backlash_e backlash_width;
	int n_fail = 0;
	int num_checks = 0;
	int seed = 32'h683d;
	int r;
	logic [7:0] act [0:12];
	logic [7:0] shd [0:12];
	logic [7:0] rv;
	logic [9:0] m [0:3];

	input_loop_ctrl DUT (.core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.io_update(io_update), .first_reference_input_tick(tick[0]),
		.second_reference_input_tick(tick[1]), .test_ref_tick(tick[2]),
		.feedback_tick(tick[3]), .first_ref_pulse(pulse[0]), .second_ref_pulse(pulse[1]),
		.test_ref_pulse(pulse[2]), .feedback_pulse(pulse[3]), .pump_hiz(pump_hiz),
		.pump_current(pump_current), .pump_mode(pump_mode), .backlash_width(backlash_width));

	// 25 MHz clock
	always #20 core_clk = ~core_clk;

	// Storage mask of each byte; reserved and unmapped places keep nothing
	function automatic logic [7:0] mask_of(input logic [11:0] a);
		case (a)
			`OFF_REF_A_HIGH, `OFF_REF_B_HIGH, `OFF_FB_HIGH: mask_of = `HIGH_MASK;
			`OFF_TEST_REF: mask_of = `TEST_MASK;
			`OFF_PUMP_MODE: mask_of = `MODE_MASK;
			`OFF_MISC: mask_of = `MISC_MASK;
			`OFF_REF_A_LOW, `OFF_REF_B_LOW, `OFF_FB_LOW, `OFF_PUMP_CUR: mask_of = 8'hFF;
			default: mask_of = 8'h00;
		endcase
	endfunction : mask_of

	// Divide ratio seen at the pins; zero behaves as one
	function automatic logic [15:0] eff(input logic [9:0] v);
		eff = (v == 10'h000) ? 16'h0001 : {6'h00, v};
	endfunction : eff

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test

	// One-cycle strobes, launched just after the edge
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge core_clk);
		#1;
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge core_clk);
		#1 reg_wr = 1'b0;
	endtask : wr

	task automatic rd(input logic [11:0] a);
		@(posedge core_clk);
		#1;
		reg_rd = 1'b1;
		reg_addr = a;
		@(posedge core_clk);
		#1 reg_rd = 1'b0;
		@(posedge core_clk);
		#1 rv = reg_rdata;
	endtask : rd

	task automatic upd();
		@(posedge core_clk);
		#1 io_update = 1'b1;
		@(posedge core_clk);
		#1 io_update = 1'b0;
		repeat (3) @(posedge core_clk);
		#1;
	endtask : upd

	// Whole bank read back; sel picks the pending copy
	task automatic cmp_bank(input logic sel);
		for (int i = 0; i < 13; i++) begin
			rd(12'h010 + 12'(i));
			check("bank byte", {8'h00, rv}, {8'h00, (sel ? shd[i] : act[i]) & mask_of(12'h010 + 12'(i))});
		end
		rd(12'h0FF);
		check("unmapped", {8'h00, rv}, 16'h0000);
	endtask : cmp_bank

	task automatic pump_chk(input logic [7:0] pc, input logic [7:0] pm);
		check("hiz", {15'h0000, pump_hiz}, {15'h0000, pc[7]});
		check("current", {9'h000, pump_current}, {9'h000, pc[6:0]});
		check("mode", {14'h0000, pump_mode}, {14'h0000, pm[1:0]});
		check("backlash", {14'h0000, backlash_width}, {14'h0000, pm[4] ? pm[3:2] : `BACKLASH_HIGH});
	endtask : pump_chk

	// Cycles between the second and third pulse; the wait left over from the old ratio and one full period are skipped
	task automatic period(input int idx, input logic [15:0] exp);
		int n;
		for (int k = 0; k < 3; k++) begin
			n = (k == 2) ? 1 : 0;
			if (k > 0) @(posedge core_clk);
			#1;
			while (pulse[idx] !== 1'b1 && n < 2100) begin
				@(posedge core_clk);
				#1 n++;
			end
		end
		check("divide period", 16'(n), exp);
	endtask : period

	// Watchdog sized well above the longest divider measurement
	initial begin
		#(40 * 80000);
		n_fail++;
		finish_test();
	end

	initial begin
		for (int i = 0; i < 13; i++) act[i] = (i == 9) ? `RST_PUMP_MODE : `RST_BYTE;
		repeat (20) @(posedge core_clk);
		#1 rst = 1'b0;
		pump_chk(8'h00, 8'h08);
		// Shadow copy versus applied copy, first pass all ones into reserved bits
		for (int it = 0; it < 4; it++) begin
			for (int i = 0; i < 13; i++) begin
				r = $random(seed);
				shd[i] = (it == 0) ? 8'hFF : r[7:0];
				wr(12'h010 + 12'(i), shd[i]);
			end
			wr(12'h0FF, 8'hFF);
			pump_chk(act[8], act[9]);
			cmp_bank(1'b0);
			wr(`OFF_READBACK, 8'hFF);
			cmp_bank(1'b1);
			rd(`OFF_READBACK);
			check("readback sel", {8'h00, rv}, 16'h0001);
			wr(`OFF_READBACK, 8'h00);
			upd();
			for (int i = 0; i < 13; i++) act[i] = shd[i];
			pump_chk(act[8], act[9]);
			cmp_bank(1'b0);
		end
		$display("test bank done");
		// Every pump mode and backlash code, override off and on
		for (int i = 0; i < 8; i++) begin
			r = $random(seed);
			wr(`OFF_PUMP_CUR, r[7:0]);
			wr(`OFF_PUMP_MODE, {3'h0, i[2], i[1:0], i[1:0]});
			upd();
			pump_chk(r[7:0], {3'h0, i[2], i[1:0], i[1:0]});
		end
		$display("test pump done");
		// Divider periods with counting enables held high
		tick = 4'hF;
		for (int it = 0; it < 5; it++) begin
			for (int j = 0; j < 4; j++) begin
				r = $random(seed);
				m[j] = {6'h00, r[3:0]};
			end
			if (it == 0) begin
				m[0] = 10'h000;
				m[1] = 10'h001;
				m[2] = 10'h03F;
				m[3] = 10'h3FF;
			end
			wr(`OFF_REF_A_LOW, m[0][7:0]);
			wr(`OFF_REF_A_HIGH, {6'h00, m[0][9:8]});
			wr(`OFF_REF_B_LOW, m[1][7:0]);
			wr(`OFF_REF_B_HIGH, {6'h00, m[1][9:8]});
			wr(`OFF_TEST_REF, m[2][7:0]);
			wr(`OFF_FB_LOW, m[3][7:0]);
			wr(`OFF_FB_HIGH, {6'h00, m[3][9:8]});
			// Independent on even passes so the hand-picked second ratio is really used
			wr(`OFF_MISC, {~it[0], 7'h00});
			upd();
			period(0, eff(m[0]));
			period(1, eff(it[0] ? m[0] : m[1]));
			period(2, eff(m[2]));
			period(3, eff(m[3]));
		end
		$display("test dividers done");
		finish_test();
	end
endmodule : input_loop_ctrl_tb
